// ### design/hadec_top.sv
// Host address decoder: routing, shadow protection, VME config and arbitration
`timescale 1ns/1ps
module hadec_top
  import hadec_pkg::*;
(
  input  wire logic           clk_sys,    // System clock, 100 MHz
  input  wire logic           reset,      // Synchronous, active high
  input  wire hadec_wb_req_t  wbReq,      // Wishbone request
  output logic [31:0]         wbDatO,     // Wishbone read data
  output logic                wbAck,      // Wishbone acknowledge
  input  wire hadec_cpu_req_t cpuReq,     // Processor access
  output hadec_route_t        route,      // Decoded target
  input  wire logic           videoPop,   // Onboard video fitted pin
  input  wire hadec_vme_acc_t vmeAcc,     // VME short-space access pins
  output logic [15:0]         vmeDatOut,  // VME read data
  output logic                vmeDatOe,   // VME data drive enable
  output logic                vmeAck,     // VME access acknowledge
  input  wire logic [3:0]     vmeBusReq,  // Backplane request lines
  input  wire logic           vmeGrantIn, // Grant reaching this module
  input  wire logic           vmeDone,    // VME master finished
  output logic [3:0]          busReqOut,  // Request line drive
  output logic                busBusy,    // Bus owned
  output logic [3:0]          arbGrant    // Slot-1 grants
);

  typedef struct packed {
    logic [7:0]   sysCtl;
    logic [15:0]  vmeCfg;
    logic [2:0]   memCfg;
    logic         wbAck;
    logic [31:0]  wbDat;
    hadec_route_t route;
    logic         want;
    logic         owned;
    logic [3:0]   busReq;
    logic         vmeAck;
    logic         vmeOe;
    logic [15:0]  vmeDat;
  } hadec_top_st_t;

  hadec_top_st_t  st;
  hadec_top_st_t  next_st;
  hadec_vme_acc_t sVme;
  logic           sVideo;
  logic [3:0]     sReq;
  logic           sGrant;
  logic           wbHit;
  logic           laMatch;
  logic [3:0]     others;
  logic [1:0]     level;
  hadec_route_t   dec;
  logic [31:0]    rdData;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  hadec_sync #(
    .W (40)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     ({videoPop, vmeBusReq, vmeGrantIn, vmeAcc}),
    .dout    ({sVideo, sReq, sGrant, sVme})
  );

  // Slot-1 arbiter
  hadec_arbiter #(
    .N (4)
  ) u_arb (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .enable     (st.vmeCfg[VC_SLOT1_BIT]),
    .roundRobin (st.vmeCfg[VC_RR_BIT]),
    .req        (sReq),
    .grant      (arbGrant)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Highest installed DRAM address
  function automatic logic [31:0] dramTop(input logic [1:0] size);
    case (size)
      2'd0:    dramTop = TOP_8M;
      2'd1:    dramTop = TOP_16M;
      default: dramTop = TOP_32M;
    endcase
  endfunction

  // One target per access, first match wins
  function automatic hadec_route_t decode(
    input hadec_cpu_req_t r,
    input logic [7:0]     sys,
    input logic [2:0]     mem,
    input logic           vid
  );
    hadec_route_t d;
    logic         prot;
    d = '0;
    prot = mem[MC_WP_BIT] && r.we;
    d.valid = r.valid;
    d.target = TGT_EXM;
    if (!r.valid) begin
      d.target = TGT_NONE;
    end else if (r.io) begin
      // Flash array registers live in slot 31 of expansion
      d.exmSlot = FLASH_SLOT;
    end else if (r.addr >= FLASH_BASE) begin
      d.target = TGT_FLASH;
    end else if (r.addr >= VME_BASE) begin
      d.target = TGT_VME;
      d.vmeMode = r.addr[31:28];
    end else if (r.addr < VIDEO_LO) begin
      d.target = TGT_DRAM;
    end else if (r.addr <= VIDEO_HI) begin
      if (vid && sys[SYS_VIDEO_BIT]) begin
        d.target = TGT_LOCAL;
      end
    end else if (r.addr <= VSHADOW_HI) begin
      d.target = TGT_DRAM;
      d.wrInhibit = prot;
    end else if (r.addr <= UMB_HI) begin
      d.target = TGT_EXM;
    end else if (r.addr <= EPAGE_HI) begin
      if (sys[SYS_EPAGE_BIT]) begin
        d.target = TGT_VME;
        d.vmeMode = EPAGE_MODE;
      end
    end else if (r.addr <= SSHADOW_HI) begin
      d.target = TGT_DRAM;
      d.wrInhibit = prot;
    end else if (r.addr <= dramTop(mem[1:0])) begin
      d.target = TGT_DRAM;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational helpers
  assign dec = decode(cpuReq, st.sysCtl, st.memCfg, sVideo);
  assign wbHit = wbReq.cyc && wbReq.stb && !st.wbAck;
  assign laMatch = sVme.addr[15:6] == {CFG_BASE[15:14], st.vmeCfg[7:0]};
  assign others = sReq & ~st.busReq;
  assign level = st.vmeCfg[VC_LVL_LSB +: 2];

  // Register read multiplexer
  always_comb begin
    rdData = '0;
    case (wbReq.adr[17:2])
      IDX_VMECFG: rdData[15:0] = st.vmeCfg;
      IDX_MEMCFG: rdData[2:0] = st.memCfg;
      IDX_SYSCTL: rdData[7:0] = st.sysCtl;
      IDX_STATUS: rdData[12:0] = {arbGrant, st.route.target, st.busReq,
                                  st.owned, st.want};
      default:    rdData = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    next_st.route = dec;

    // VME side: answer once per strobe in our window
    if (!sVme.strobe) begin
      next_st.vmeAck = 1'b0;
      next_st.vmeOe = 1'b0;
    end else if (laMatch && !st.vmeAck) begin
      next_st.vmeAck = 1'b1;
      next_st.vmeOe = !sVme.we;
      next_st.vmeDat = '0;
      case (sVme.addr[5:0])
        6'h00: begin
          if (sVme.we) next_st.vmeCfg = sVme.data;
          next_st.vmeDat = st.vmeCfg;
        end
        6'h02: begin
          if (sVme.we) next_st.sysCtl = sVme.data[7:0];
          next_st.vmeDat = {8'h00, st.sysCtl};
        end
        6'h04: begin
          if (sVme.we) next_st.memCfg = sVme.data[2:0];
          next_st.vmeDat = {13'h0000, st.memCfg};
        end
        default: next_st.vmeDat = '0;
      endcase
    end

    // Wishbone side, later so it wins a same-cycle clash
    next_st.wbAck = wbHit;
    if (wbHit) begin
      next_st.wbDat = rdData;
      if (wbReq.we) begin
        case (wbReq.adr[17:2])
          IDX_VMECFG: begin
            if (wbReq.sel[0]) next_st.vmeCfg[7:0] = wbReq.dat[7:0];
            if (wbReq.sel[1]) next_st.vmeCfg[15:8] = wbReq.dat[15:8];
          end
          IDX_MEMCFG: if (wbReq.sel[0]) next_st.memCfg = wbReq.dat[2:0];
          IDX_SYSCTL: if (wbReq.sel[0]) next_st.sysCtl = wbReq.dat[7:0];
          default: ;
        endcase
      end
    end

    // Own VME mastership
    if (dec.target == TGT_VME) begin
      next_st.want = 1'b1;
    end else if (vmeDone) begin
      next_st.want = 1'b0;
    end
    if (!st.owned && st.want && sGrant) begin
      next_st.owned = 1'b1;
    end else if (st.owned && !st.want &&
                 (!st.vmeCfg[VC_ROR_BIT] || others != '0)) begin
      next_st.owned = 1'b0;
    end
    next_st.busReq = '0;
    if (next_st.want && !next_st.owned) begin
      next_st.busReq = 4'h1 << level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.sysCtl <= SYSCTL_RST;
      st.vmeCfg <= VMECFG_RST;
      st.memCfg <= MEMCFG_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign wbDatO = st.wbDat;
  assign wbAck = st.wbAck;
  assign route = st.route;
  assign vmeDatOut = st.vmeDat;
  assign vmeDatOe = st.vmeOe;
  assign vmeAck = st.vmeAck;
  assign busReqOut = st.busReq;
  assign busBusy = st.owned;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_flash_route: assert property (cpuReq.valid && !cpuReq.io &&
    cpuReq.addr >= FLASH_BASE |=> route.target == TGT_FLASH)
    else $error("flash range not routed to flash");

  a_vme_direct: assert property (cpuReq.valid && !cpuReq.io &&
    cpuReq.addr >= VME_BASE && cpuReq.addr < FLASH_BASE
    |=> route.target == TGT_VME &&
        route.vmeMode == $past(cpuReq.addr[31:28]))
    else $error("high address not a direct VME access");

  a_video_route: assert property (cpuReq.valid && !cpuReq.io &&
    cpuReq.addr >= VIDEO_LO && cpuReq.addr <= VIDEO_HI
    |=> route.target == (($past(sVideo) && $past(st.sysCtl[SYS_VIDEO_BIT]))
                         ? TGT_LOCAL : TGT_EXM))
    else $error("video range misrouted");

  a_epage_route: assert property (cpuReq.valid && !cpuReq.io &&
    cpuReq.addr > UMB_HI && cpuReq.addr <= EPAGE_HI
    |=> route.target == ($past(st.sysCtl[SYS_EPAGE_BIT]) ? TGT_VME : TGT_EXM))
    else $error("E page misrouted");

  a_epage_mode: assert property (cpuReq.valid && !cpuReq.io &&
    st.sysCtl[SYS_EPAGE_BIT] && cpuReq.addr > UMB_HI && cpuReq.addr <= EPAGE_HI
    |=> route.vmeMode == EPAGE_MODE)
    else $error("E page mode wrong");

  a_umb_exm: assert property (cpuReq.valid && !cpuReq.io &&
    cpuReq.addr > VSHADOW_HI && cpuReq.addr <= UMB_HI |=> route.target == TGT_EXM)
    else $error("upper memory not on expansion");

  a_low_dram: assert property (cpuReq.valid && !cpuReq.io &&
    cpuReq.addr < VIDEO_LO |=> route.target == TGT_DRAM)
    else $error("base memory not on DRAM");

  a_vshadow_dram: assert property (cpuReq.valid && !cpuReq.io &&
    cpuReq.addr > VIDEO_HI && cpuReq.addr <= VSHADOW_HI |=> route.target == TGT_DRAM)
    else $error("video shadow not on DRAM");

  a_vshadow_prot: assert property (cpuReq.valid && !cpuReq.io && cpuReq.we &&
    st.memCfg[MC_WP_BIT] && cpuReq.addr > VIDEO_HI && cpuReq.addr <= VSHADOW_HI
    |=> route.target == TGT_DRAM && route.wrInhibit)
    else $error("video shadow write not inhibited");

  a_shadow_prot: assert property (cpuReq.valid && !cpuReq.io && cpuReq.we &&
    st.memCfg[MC_WP_BIT] && cpuReq.addr > EPAGE_HI &&
    cpuReq.addr <= SSHADOW_HI
    |=> route.target == TGT_DRAM && route.wrInhibit)
    else $error("protected shadow write not inhibited");

  a_dram_size: assert property (cpuReq.valid && !cpuReq.io &&
    st.memCfg[1:0] == 2'd0 && cpuReq.addr > TOP_8M && cpuReq.addr <= TOP_16M
    |=> route.target == TGT_EXM)
    else $error("8 Mbyte hole not on expansion");

  a_dram_16m: assert property (cpuReq.valid && !cpuReq.io &&
    st.memCfg[1:0] == 2'd1 && cpuReq.addr > TOP_8M && cpuReq.addr <= TOP_16M
    |=> route.target == TGT_DRAM)
    else $error("16 Mbyte range not on DRAM");

  a_dram_32m: assert property (cpuReq.valid && !cpuReq.io &&
    st.memCfg[1] && cpuReq.addr > TOP_16M && cpuReq.addr <= TOP_32M
    |=> route.target == TGT_DRAM)
    else $error("32 Mbyte range not on DRAM");

  a_hole_exm: assert property (cpuReq.valid && !cpuReq.io &&
    cpuReq.addr > TOP_32M && cpuReq.addr < VME_BASE |=> route.target == TGT_EXM)
    else $error("unclaimed address not on expansion");

  a_one_target: assert property (route.valid |-> route.target != TGT_NONE)
    else $error("valid access without target");

  a_slot31_io: assert property (cpuReq.valid && cpuReq.io
    |=> route.target == TGT_EXM && route.exmSlot == FLASH_SLOT)
    else $error("flash I/O not in slot 31");

  a_la_answer: assert property (sVme.strobe && laMatch && !vmeAck
    |=> vmeAck)
    else $error("config window access not answered");

  a_read_drive: assert property (vmeDatOe |-> vmeAck)
    else $error("VME data driven without answer");

  a_wb_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("register ack held");

  a_req_level: assert property (busReqOut == '0 ||
    busReqOut == (4'h1 << $past(level)))
    else $error("wrong request line driven");

  a_ror_hold: assert property (busBusy && st.vmeCfg[VC_ROR_BIT] &&
    others == '0 |=> busBusy)
    else $error("released bus with no other request");

  c_flash: cover property (route.target == TGT_FLASH);
  c_video_local: cover property (route.target == TGT_LOCAL);
  c_arb_grant: cover property (arbGrant != '0);
  c_vme_own: cover property (busBusy ##1 !busBusy);
  c_cfg_write: cover property (sVme.strobe && sVme.we && laMatch ##1 vmeAck);

endmodule

// ### design/hadec_pkg.sv
// Constants, field layouts and carrier types of the host address decoder
// What this block does
// - Video range A0000-BFFFF goes to local bus if video fitted and enabled, else expansion.
// - Range E0000-EFFFF goes to expansion or a VME window, chosen by control bit 1.
// - Upper memory C8000-DFFFF goes to the expansion interface.
// - C0000-C7FFF and F0000-FFFFF come from DRAM that can be write-protected.
// - Addresses from 256 Mbytes up to FFF7FFFF are direct VME accesses; address picks mode and order.
// - With 8 Mbytes, 100000-7FFFFF is DRAM and 800000-FFFFFF is expansion.
// - With 16 Mbytes, 100000-FFFFFF is DRAM.
// - With 32 Mbytes, 100000-1FFFFFF is DRAM.
// - The top 512 Kbytes, FFF80000-FFFFFFFF, select the flash boot device.
// - Config registers answer in VME short space at C000 plus logical address times 40.
// - Config registers are read and written from both VME and the local processor.
// - Request level 0 to 3 picks the VME request line driven; 0 is highest.
// - As slot-1 arbiter, grant four lines round-robin or fixed with line 0 highest.
// - Bus release either on no own request or on another party's request.
// - Resident flash sits behind I/O registers and appears as expansion slot 31.
// - DRAM and video use the 32-bit local bus; slow peripherals use expansion.
// - Writes to protected shadow DRAM complete but leave DRAM unchanged.
// - Control bit 2 enables onboard video and so steers the video range.
package hadec_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_VMECFG = 16'h8100;
  localparam logic [15:0] IDX_MEMCFG = 16'h8101;
  localparam logic [15:0] IDX_SYSCTL = 16'h8102;
  localparam logic [15:0] IDX_STATUS = 16'h8103;

  // Field positions
  localparam int SYS_EPAGE_BIT = 1;
  localparam int SYS_VIDEO_BIT = 2;
  localparam int VC_LA_LSB     = 0;
  localparam int VC_LVL_LSB    = 8;
  localparam int VC_RR_BIT     = 10;
  localparam int VC_ROR_BIT    = 11;
  localparam int VC_SLOT1_BIT  = 12;
  localparam int MC_WP_BIT     = 2;

  // Reset values
  localparam logic [7:0]  SYSCTL_RST = 8'h00;
  localparam logic [15:0] VMECFG_RST = 16'h0000;
  localparam logic [2:0]  MEMCFG_RST = 3'h0;

  // Memory map
  localparam logic [31:0] VIDEO_LO   = 32'h000A_0000;
  localparam logic [31:0] VIDEO_HI   = 32'h000B_FFFF;
  localparam logic [31:0] VSHADOW_HI = 32'h000C_7FFF;
  localparam logic [31:0] UMB_HI     = 32'h000D_FFFF;
  localparam logic [31:0] EPAGE_HI   = 32'h000E_FFFF;
  localparam logic [31:0] SSHADOW_HI = 32'h000F_FFFF;
  localparam logic [31:0] TOP_8M     = 32'h007F_FFFF;
  localparam logic [31:0] TOP_16M    = 32'h00FF_FFFF;
  localparam logic [31:0] TOP_32M    = 32'h01FF_FFFF;
  localparam logic [31:0] VME_BASE   = 32'h1000_0000;
  localparam logic [31:0] FLASH_BASE = 32'hFFF8_0000;
  localparam logic [15:0] CFG_BASE   = 16'hC000;
  localparam logic [4:0]  FLASH_SLOT = 5'h1F;
  localparam logic [3:0]  EPAGE_MODE = 4'h0;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_DRAM, TGT_LOCAL, TGT_EXM, TGT_FLASH, TGT_VME
  } hadec_target_t;

  typedef struct packed {
    logic        valid;
    logic        io;
    logic        we;
    logic [31:0] addr;
  } hadec_cpu_req_t;

  typedef struct packed {
    logic          valid;
    hadec_target_t target;
    logic [3:0]    vmeMode;
    logic [4:0]    exmSlot;
    logic          wrInhibit;
  } hadec_route_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [17:0] adr;
    logic [31:0] dat;
  } hadec_wb_req_t;

  typedef struct packed {
    logic        strobe;
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
  } hadec_vme_acc_t;

endpackage

// ### design/hadec_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module hadec_sync
  import hadec_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys, // System clock
  input  wire logic         reset,   // Synchronous reset
  input  wire logic [W-1:0] din,     // Asynchronous pins
  output logic      [W-1:0] dout     // Synchronised copy
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } hadec_sync_st_t;

  hadec_sync_st_t st;
  hadec_sync_st_t next_st;

  if (W < 1) begin : g_bad_width
    $error("hadec_sync: width must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage one feeds only stage two
  always_comb begin
    next_st.stage1 = din;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stage2;

endmodule

// ### design/hadec_arbiter.sv
// Slot-1 arbiter for the VME request lines
`timescale 1ns/1ps
module hadec_arbiter
  import hadec_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic         clk_sys,    // System clock
  input  wire logic         reset,      // Synchronous reset
  input  wire logic         enable,     // Acting as slot-1 arbiter
  input  wire logic         roundRobin, // 1 rotate, 0 fixed
  input  wire logic [N-1:0] req,        // Synchronised requests
  output logic      [N-1:0] grant       // One-hot grant
);

  typedef struct packed {
    logic [N-1:0]         grant;
    logic [$clog2(N)-1:0] last;
  } hadec_arb_st_t;

  hadec_arb_st_t st;
  hadec_arb_st_t next_st;
  logic          found;
  int            idx;

  if (N < 2) begin : g_bad_n
    $error("hadec_arbiter: need at least two request lines");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold while owner requests, else pick next line
  always_comb begin
    next_st = st;
    found = 1'b0;
    idx = 0;
    if (!enable) begin
      next_st.grant = '0;
    end else if ((st.grant & req) == '0) begin
      next_st.grant = '0;
      for (int k = 0; k < N; k++) begin
        idx = roundRobin ? (int'(st.last) + 1 + k) % N : k;
        if (!found && req[idx]) begin
          found = 1'b1;
          next_st.grant[idx] = 1'b1;
          next_st.last = ($clog2(N))'(idx);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign grant = st.grant;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_grant_onehot: assert property ($onehot0(grant))
    else $error("arbiter granted more than one line");
  a_fixed_prio: assert property (enable && !roundRobin && grant == '0 && req[0]
    |=> grant[0])
    else $error("fixed priority did not favour line 0");

endmodule

// ### testbench/hadec_vme_far.sv
// Backplane model: request lines of other modules and grant to this one
`timescale 1ns/1ps
module hadec_vme_far
  import hadec_pkg::*;
(
  input  wire logic       clk_sys,    // System clock
  input  wire logic       reset,      // Synchronous reset
  input  wire logic [3:0] busReqOut,  // Our request drive
  input  wire logic [3:0] otherReq,   // Other modules' requests
  input  wire logic [7:0] grantDelay, // Cycles before grant
  output logic      [3:0] vmeBusReq,  // Wired-OR request lines
  output logic            vmeGrantIn  // Grant to us
);
  logic [7:0] waitCnt;
  // Wired-OR of every requester
  assign vmeBusReq = busReqOut | otherReq;
  // Grant after a delay while we request, withdrawn when we stop
  always_ff @(posedge clk_sys) begin
    if (reset || busReqOut == 4'h0) begin
      waitCnt    <= 8'h00;
      vmeGrantIn <= 1'b0;
    end else if (waitCnt >= grantDelay) begin
      vmeGrantIn <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 8'h01;
    end
  end
endmodule

// ### testbench/hadec_top_tb.sv
// Self-checking bench for the host address decoder
`timescale 1ns/1ps
module hadec_top_tb
  import hadec_pkg::*;
;
  logic           clk_sys;
  logic           reset;
  hadec_wb_req_t  wbReq;
  hadec_cpu_req_t cpuReq;
  hadec_vme_acc_t vmeAcc;
  hadec_route_t   route;
  hadec_route_t   seen;
  logic [31:0]    wbDatO;
  logic [31:0]    rd;
  logic [15:0]    vmeDatOut;
  logic [7:0]     grantDelay;
  logic [3:0]     vmeBusReq;
  logic [3:0]     busReqOut;
  logic [3:0]     arbGrant;
  logic [3:0]     otherReq;
  logic           wbAck;
  logic           videoPop;
  logic           vmeDatOe;
  logic           vmeAck;
  logic           vmeGrantIn;
  logic           vmeDone;
  logic           busBusy;
  int             failCount;
  int             nTests;
  int             cycles;

  ////////////////////////////////////////
  // Clock, design and far side
  always #5 clk_sys = ~clk_sys;

  hadec_top DUT (.clk_sys(clk_sys), .reset(reset), .wbReq(wbReq), .wbDatO(wbDatO),
    .wbAck(wbAck), .cpuReq(cpuReq), .route(route), .videoPop(videoPop),
    .vmeAcc(vmeAcc), .vmeDatOut(vmeDatOut), .vmeDatOe(vmeDatOe), .vmeAck(vmeAck),
    .vmeBusReq(vmeBusReq), .vmeGrantIn(vmeGrantIn), .vmeDone(vmeDone),
    .busReqOut(busReqOut), .busBusy(busBusy), .arbGrant(arbGrant));

  hadec_vme_far FAR (.clk_sys(clk_sys), .reset(reset), .busReqOut(busReqOut),
    .otherReq(otherReq), .grantDelay(grantDelay), .vmeBusReq(vmeBusReq),
    .vmeGrantIn(vmeGrantIn));

  ////////////////////////////////////////
  // Verdict and hang guard
  task finishTest();
    if (failCount == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      finishTest();
    end
  end

  ////////////////////////////////////////
  // Shared compare and bus tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single Wishbone cycle, held until ack
  task wb(input logic we, input logic [15:0] idx, input logic [31:0] d);
    wbReq <= {1'b1, 1'b1, we, 4'hF, idx, 2'h0, d};
    do @(posedge clk_sys); while (wbAck !== 1'b1);
    rd = wbDatO;
    wbReq <= '0;
    @(posedge clk_sys);
    chk("wbAck drop", 32'h0, {31'h0, wbAck});
  endtask

  // One processor access, route seen one edge later
  task dec(input logic [31:0] a, input logic io, input logic we, input hadec_target_t t);
    cpuReq <= {1'b1, io, we, a};
    @(posedge clk_sys);
    cpuReq <= '0;
    @(posedge clk_sys);
    seen = route;
    chk("route.valid", 32'h1, {31'h0, seen.valid});
    chk("route.target", {29'h0, t}, {29'h0, seen.target});
  endtask

  // Short-space access from another backplane module
  task vme(input logic we, input logic [15:0] a, input logic [15:0] d, input logic ack);
    vmeAcc <= {1'b0, we, a, d};
    repeat (4) @(posedge clk_sys);
    vmeAcc.strobe <= 1'b1;
    for (int k = 0; k < 12 && vmeAck !== 1'b1; k++) @(posedge clk_sys);
    chk("vmeAck", {31'h0, ack}, {31'h0, vmeAck});
    chk("vmeDatOe", {31'h0, ack & ~we}, {31'h0, vmeDatOe});
    rd = {16'h0, vmeDatOut};
    vmeAcc <= {1'b0, ~we, ~a, ~d};
    repeat (8) @(posedge clk_sys);
    chk("vmeAck idle", 32'h0, {31'h0, vmeAck});
  endtask

  ////////////////////////////////////////
  // Own VME access finished, then let the release settle
  task vmeEnd();
    vmeDone <= 1'b1;
    @(posedge clk_sys);
    vmeDone <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  // Scenarios
  task testRegs();
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, IDX_VMECFG + 16'(i), 32'h0);
      chk("reg reset", 32'h0, rd);
    end
    wb(1'b0, 16'h0010, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, IDX_MEMCFG, 32'h5);
    wb(1'b0, IDX_MEMCFG, 32'h0);
    chk("memcfg", 32'h5, rd);
    wb(1'b1, IDX_MEMCFG, 32'h0);
  endtask

  task testLowMap();
    dec(32'h0000_0000, 1'b0, 1'b0, TGT_DRAM);
    dec(32'h000C_7FFF, 1'b0, 1'b0, TGT_DRAM);
    dec(32'h000F_0000, 1'b0, 1'b0, TGT_DRAM);
    dec(32'h000C_8000, 1'b0, 1'b0, TGT_EXM);
    dec(32'h000D_FFFF, 1'b0, 1'b0, TGT_EXM);
    dec(32'h000E_0000, 1'b0, 1'b0, TGT_EXM);
    wb(1'b1, IDX_SYSCTL, 32'h2);
    dec(32'h000E_FFFF, 1'b0, 1'b0, TGT_VME);
    chk("epage mode", 32'h0, {28'h0, seen.vmeMode});
    wb(1'b1, IDX_SYSCTL, 32'h4);
    dec(32'h000A_0000, 1'b0, 1'b0, TGT_EXM);
    videoPop <= 1'b1;
    repeat (4) @(posedge clk_sys);
    dec(32'h000B_FFFF, 1'b0, 1'b0, TGT_LOCAL);
    wb(1'b1, IDX_SYSCTL, 32'h0);
    dec(32'h000A_0000, 1'b0, 1'b0, TGT_EXM);
    dec(32'hFFF8_0000, 1'b0, 1'b0, TGT_FLASH);
    dec(32'hFFFF_FFFF, 1'b0, 1'b0, TGT_FLASH);
    dec(32'hFFF7_FFFF, 1'b0, 1'b0, TGT_VME);
    chk("direct mode", 32'hF, {28'h0, seen.vmeMode});
    dec(32'h1000_0000, 1'b0, 1'b0, TGT_VME);
    dec(32'h0FFF_FFFF, 1'b0, 1'b0, TGT_EXM);
    dec(32'h0000_0100, 1'b1, 1'b0, TGT_EXM);
    chk("exm slot", 32'h1F, {27'h0, seen.exmSlot});
    vmeEnd();
  endtask

  task testSizes();
    logic [31:0] top;
    logic [31:0] probe [6];
    probe = '{32'h007F_FFFF, 32'h0080_0000, 32'h00FF_FFFF, 32'h0100_0000,
              32'h01FF_FFFF, 32'h0200_0000};
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, IDX_MEMCFG, 32'(s));
      top = (s == 0) ? TOP_8M : (s == 1) ? TOP_16M : TOP_32M;
      for (int p = 0; p < 6; p++) begin
        dec(probe[p], 1'b0, 1'b0, (probe[p] <= top) ? TGT_DRAM : TGT_EXM);
      end
    end
    wb(1'b1, IDX_MEMCFG, 32'h4);
    dec(32'h000C_0000, 1'b0, 1'b1, TGT_DRAM);
    chk("inhibit", 32'h1, {31'h0, seen.wrInhibit});
    dec(32'h000F_0000, 1'b0, 1'b0, TGT_DRAM);
    chk("read free", 32'h0, {31'h0, seen.wrInhibit});
    dec(32'h000F_FFFF, 1'b0, 1'b1, TGT_DRAM);
    chk("bios inhibit", 32'h1, {31'h0, seen.wrInhibit});
    dec(32'h0010_0000, 1'b0, 1'b1, TGT_DRAM);
    chk("plain dram", 32'h0, {31'h0, seen.wrInhibit});
    wb(1'b1, IDX_MEMCFG, 32'h0);
  endtask

  task testVmeCfg();
    wb(1'b1, IDX_VMECFG, 32'h0205);
    vme(1'b1, 16'hC142, 16'h0002, 1'b1);
    wb(1'b0, IDX_SYSCTL, 32'h0);
    chk("sysctl by vme", 32'h2, rd);
    vme(1'b0, 16'hC140, 16'h0000, 1'b1);
    chk("vmecfg by vme", 32'h0205, rd);
    vme(1'b0, 16'hC100, 16'h0000, 1'b0);
    wb(1'b1, IDX_VMECFG, 32'h02FF);
    vme(1'b0, 16'hFFC0, 16'h0000, 1'b1);
    chk("top window", 32'h02FF, rd);
    vme(1'b0, 16'hFFF0, 16'h0000, 1'b1);
    chk("top offset", 32'h0, rd);
    wb(1'b1, IDX_SYSCTL, 32'h0);
  endtask

  task masterRun(input logic [1:0] lvl, input logic release_on_request);
    wb(1'b1, IDX_VMECFG, {20'h0, release_on_request, 1'b0, lvl, 8'hFF});
    dec(32'h3000_0000, 1'b0, 1'b0, TGT_VME);
    for (int k = 0; k < 20 && busReqOut === 4'h0; k++) @(posedge clk_sys);
    chk("busReqOut", {28'h0, 4'h1 << lvl}, {28'h0, busReqOut});
    for (int k = 0; k < 30 && busBusy !== 1'b1; k++) @(posedge clk_sys);
    chk("busBusy", 32'h1, {31'h0, busBusy});
    vmeEnd();
    chk("held after done", {31'h0, release_on_request}, {31'h0, busBusy});
    otherReq <= 4'h8;
    for (int k = 0; k < 10 && busBusy !== 1'b0; k++) @(posedge clk_sys);
    chk("released", 32'h0, {31'h0, busBusy});
    otherReq <= 4'h0;
    repeat (4) @(posedge clk_sys);
  endtask

  task arbRun(input logic [3:0] req, input logic [3:0] exp);
    otherReq <= req;
    for (int k = 0; k < 10 && arbGrant === 4'h0; k++) @(posedge clk_sys);
    chk("arbGrant", {28'h0, exp}, {28'h0, arbGrant});
    otherReq <= 4'h0;
    for (int k = 0; k < 10 && arbGrant !== 4'h0; k++) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    wbReq = '0;
    cpuReq = '0;
    vmeAcc = '0;
    videoPop = 1'b0;
    vmeDone = 1'b0;
    otherReq = 4'h0;
    grantDelay = 8'h03;
    failCount = 0;
    nTests = 0;
    cycles = 0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    testRegs();
    testLowMap();
    testSizes();
    testVmeCfg();
    for (int l = 0; l < 4; l++) masterRun(l[1:0], 1'b0);
    masterRun(2'h1, 1'b1);
    wb(1'b1, IDX_VMECFG, 32'h1000);
    arbRun(4'h6, 4'h2);
    arbRun(4'h9, 4'h1);
    wb(1'b1, IDX_VMECFG, 32'h1400);
    arbRun(4'h3, 4'h2);
    finishTest();
  end
endmodule
